//--- inc/serial_port_regs.vh
// Constants for the serial port unit: register offsets, fields, reset values, timing.
// Assumes a classic Wishbone slave with 32-bit data and word-index addresses, one register per address.
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

`define OFS_MODE        4'h0
`define OFS_CONTROL     4'h1
`define OFS_HOLDING     4'h2
`define OFS_STATUS      4'h3
`define OFS_RXDATA      4'h4
`define OFS_BAUD        4'h5
`define OFS_OWN_ID      4'h6

// Mode register fields
`define MODE_SYNC       0
`define MODE_SEVEN      1
`define MODE_PARITY     2
`define MODE_ODD        3
`define MODE_TWO_STOP   4
`define MODE_MP         5

// Control register fields
`define CTL_TX_EN       0
`define CTL_RX_EN       1
`define CTL_TIE         2
`define CTL_TX_END_IRQ_ENABLE        3
`define CTL_RIE         4
`define CTL_CLKSEL      5
`define CTL_PORT_DIR    6
`define CTL_PORT_LVL    7

// Status register fields
`define ST_TX_EMPTY     0
`define ST_TX_END       1
`define ST_RX_FULL      2
`define ST_OVERRUN      3
`define ST_FRAMING      4
`define ST_PARITY       5
`define ST_MP_SEND      6
`define ST_MP_RECV      7

`define RESET_STATUS    8'h03
`define RESET_BAUD      8'h07
`define OVERSAMPLE      5'd16
`define MID_SAMPLE      5'd8

`endif

//--- verilog/serial_bit_clock.v
// Baud tick generator: one-cycle tick every (divisor+1) system clocks.
// Assumes a free running system clock; restarts whenever held off.
`timescale 1ns/1ns
`default_nettype none
module serial_bit_clock (
    // System
    input  wire       CLOCK,
    input  wire       RSTN,
    // Control
    input  wire       ENABLE,
    input  wire [7:0] DIVISOR,
    // Tick
    output reg        TICK
);
    reg [7:0] count;

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            count <= 8'h00;
            TICK  <= 1'b0;
        end else if (!ENABLE) begin
            count <= 8'h00;
            TICK  <= 1'b0;
        end else if (count >= DIVISOR) begin
            count <= 8'h00;
            TICK  <= 1'b1;
        end else begin
            count <= count + 8'h01;
            TICK  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- verilog/serial_port_unit.v
// Serial port unit: asynchronous with multiprocessor format, or clocked synchronous.
// Assumes a classic Wishbone master, pins synchronous to CLOCK, and a DMA that strobes DMA_WRITE.
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_regs.vh"
module serial_port_unit (
    // System
    input  wire        CLOCK,
    input  wire        RSTN,
    // Wishbone slave
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [3:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output wire        WB_ACK_O,
    // DMA transmit path
    input  wire        DMA_WRITE,
    input  wire [7:0]  DMA_DATA,
    // Requests
    output wire        TX_EMPTY_REQUEST,
    output wire        TX_END_REQUEST,
    output wire        RX_FULL_REQUEST,
    // Serial pins
    output reg         TXD,
    input  wire        RXD,
    input  wire        SCK_IN,
    output reg         SCK_OUT,
    output wire        SCK_OE_N
);
    localparam TX_IDLE  = 3'd0;
    localparam TX_START = 3'd1;
    localparam TX_DATA  = 3'd2;
    localparam TX_EXTRA = 3'd3;
    localparam TX_STOP  = 3'd4;

    reg  [7:0] mode;
    reg  [7:0] control;
    reg  [7:0] status;
    reg  [7:0] baud;
    reg  [7:0] own_id;
    reg  [7:0] tx_holding_reg;
    reg  [7:0] tx_shift_reg;
    reg  [7:0] rx_data;
    reg  [7:0] rx_shift;
    reg        ack;
    reg  [2:0] tx_state;
    reg  [3:0] tx_bits;
    reg  [4:0] tx_os;
    reg        tx_stop2;
    reg        tx_extra;
    reg  [2:0] rx_state;
    reg  [3:0] rx_bits;
    reg  [4:0] rx_os;
    reg        rx_extra;
    reg        rx_stop_ok;
    reg        rx_match;
    reg        rx_second;
    reg        sck_prev;
    reg        sck_int;
    reg        sck_run;
    reg  [3:0] sck_count;
    reg        tx_end_pulse;
    reg        tx_load_pulse;
    reg        rx_done_pulse;
    wire       tick;

    wire       sync_mode = mode[`MODE_SYNC];
    wire       mp_mode   = mode[`MODE_MP] & ~sync_mode;
    wire       tx_en     = control[`CTL_TX_EN];
    wire       rx_en     = control[`CTL_RX_EN];
    wire       ext_clk   = control[`CTL_CLKSEL];
    wire [3:0] char_bits = (sync_mode | ~mode[`MODE_SEVEN]) ? 4'd8 : 4'd7;
    wire       use_par   = mode[`MODE_PARITY] & ~mp_mode & ~sync_mode;
    wire       use_extra = use_par | mp_mode;
    wire       wb_req    = WB_CYC_I & WB_STB_I & ~ack;
    // Writes land at the edge where the master sees ack high
    wire       wb_wr     = WB_CYC_I & WB_STB_I & ack & WB_WE_I & WB_SEL_I[0];
    wire       sck_line  = ext_clk ? SCK_IN : sck_int;
    wire       sck_rise  = sync_mode & sck_line & ~sck_prev;
    wire       sck_fall  = sync_mode & ~sck_line & sck_prev;
    wire       os_tick   = ~sync_mode & tick;

    function parity_of;
        input [7:0] d;
        input [3:0] n;
        input       odd;
        begin
            parity_of = ^(n == 4'd7 ? {1'b0, d[6:0]} : d) ^ odd;
        end
    endfunction

    assign WB_ACK_O         = ack;
    assign SCK_OE_N         = ~(sync_mode & ~ext_clk);
    assign TX_EMPTY_REQUEST = status[`ST_TX_EMPTY] & control[`CTL_TIE] & tx_en;
    assign TX_END_REQUEST   = status[`ST_TX_END] & control[`CTL_TX_END_IRQ_ENABLE] & tx_en;
    assign RX_FULL_REQUEST  = status[`ST_RX_FULL] & control[`CTL_RIE];

    serial_bit_clock baud_gen (
        .CLOCK   (CLOCK),
        .RSTN    (RSTN),
        .ENABLE  (tx_en | rx_en),
        .DIVISOR (baud),
        .TICK    (tick)
    );

    // Register bus; ack one cycle after request, dropped the next cycle
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ack      <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            ack <= wb_req;
            case (WB_ADR_I)
                `OFS_MODE:    WB_DAT_O <= {24'h000000, mode};
                `OFS_CONTROL: WB_DAT_O <= {24'h000000, control};
                `OFS_HOLDING: WB_DAT_O <= {24'h000000, tx_holding_reg};
                `OFS_STATUS:  WB_DAT_O <= {24'h000000, status};
                `OFS_RXDATA:  WB_DAT_O <= {24'h000000, rx_data};
                `OFS_BAUD:    WB_DAT_O <= {24'h000000, baud};
                `OFS_OWN_ID:  WB_DAT_O <= {24'h000000, own_id};
                default:      WB_DAT_O <= 32'h00000000;
            endcase
        end
    end

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            mode           <= 8'h00;
            control        <= 8'h00;
            baud           <= `RESET_BAUD;
            own_id         <= 8'h00;
            tx_holding_reg <= 8'h00;
        end else begin
            if (wb_wr && WB_ADR_I == `OFS_MODE)
                mode <= WB_DAT_I[7:0];
            if (wb_wr && WB_ADR_I == `OFS_CONTROL)
                control <= WB_DAT_I[7:0];
            if (wb_wr && WB_ADR_I == `OFS_BAUD)
                baud <= WB_DAT_I[7:0];
            if (wb_wr && WB_ADR_I == `OFS_OWN_ID)
                own_id <= WB_DAT_I[7:0];
            if (DMA_WRITE)
                tx_holding_reg <= DMA_DATA;
            else if (wb_wr && WB_ADR_I == `OFS_HOLDING)
                tx_holding_reg <= WB_DAT_I[7:0];
        end
    end

    // Status: hardware sets win over software clears (write 0 clears)
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            status <= `RESET_STATUS;
        end else begin
            if (wb_wr && WB_ADR_I == `OFS_STATUS) begin
                status[`ST_TX_EMPTY] <= status[`ST_TX_EMPTY] & WB_DAT_I[`ST_TX_EMPTY];
                status[`ST_TX_END]   <= status[`ST_TX_END] & WB_DAT_I[`ST_TX_END];
                status[`ST_RX_FULL]  <= status[`ST_RX_FULL] & WB_DAT_I[`ST_RX_FULL];
                status[`ST_OVERRUN]  <= status[`ST_OVERRUN] & WB_DAT_I[`ST_OVERRUN];
                status[`ST_FRAMING]  <= status[`ST_FRAMING] & WB_DAT_I[`ST_FRAMING];
                status[`ST_PARITY]   <= status[`ST_PARITY] & WB_DAT_I[`ST_PARITY];
                status[`ST_MP_SEND]  <= WB_DAT_I[`ST_MP_SEND];
            end
            if (DMA_WRITE && status[`ST_TX_EMPTY])
                status[`ST_TX_EMPTY] <= 1'b0;
            if (!tx_en) begin
                status[`ST_TX_EMPTY] <= 1'b1;
                status[`ST_TX_END]   <= 1'b1;
            end
            if (tx_load_pulse) begin
                status[`ST_TX_EMPTY] <= 1'b1;
                status[`ST_TX_END]   <= 1'b0;
            end
            if (tx_end_pulse)
                status[`ST_TX_END] <= 1'b1;
            if (rx_done_pulse) begin
                if (status[`ST_RX_FULL]) begin
                    status[`ST_OVERRUN] <= 1'b1;
                end else begin
                    status[`ST_RX_FULL] <= 1'b1;
                    status[`ST_MP_RECV] <= rx_extra;
                    if (!sync_mode) begin
                        status[`ST_FRAMING] <= ~rx_stop_ok;
                        status[`ST_PARITY]  <= use_par &
                            (parity_of(rx_shift, char_bits, mode[`MODE_ODD]) != rx_extra);
                    end
                end
            end
        end
    end

    // Transmitter
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            tx_state      <= TX_IDLE;
            tx_shift_reg  <= 8'h00;
            tx_bits       <= 4'd0;
            tx_os         <= 5'd0;
            tx_stop2      <= 1'b0;
            tx_extra      <= 1'b0;
            TXD           <= 1'b1;
            tx_load_pulse <= 1'b0;
            tx_end_pulse  <= 1'b0;
        end else begin
            tx_load_pulse <= 1'b0;
            tx_end_pulse  <= 1'b0;
            if (!tx_en) begin
                tx_state <= TX_IDLE;
                TXD      <= control[`CTL_PORT_DIR] ? control[`CTL_PORT_LVL] : 1'b1;
            end else if (sync_mode) begin
                case (tx_state)
                    TX_IDLE: begin
                        if (!status[`ST_TX_EMPTY] && !tx_load_pulse) begin
                            tx_shift_reg  <= tx_holding_reg;
                            tx_load_pulse <= 1'b1;
                            tx_bits       <= 4'd0;
                            tx_state      <= TX_DATA;
                        end
                    end
                    TX_DATA: begin
                        if (sck_fall) begin
                            TXD          <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                            tx_bits      <= tx_bits + 4'd1;
                            if (tx_bits == 4'd7) begin
                                if (!status[`ST_TX_EMPTY]) begin
                                    tx_state <= TX_IDLE;
                                end else begin
                                    tx_end_pulse <= 1'b1;
                                    tx_state     <= TX_IDLE;
                                end
                            end
                        end
                    end
                    default: tx_state <= TX_IDLE;
                endcase
            end else begin
                if (tx_state != TX_IDLE && os_tick)
                    tx_os <= (tx_os == `OVERSAMPLE - 5'd1) ? 5'd0 : tx_os + 5'd1;
                case (tx_state)
                    TX_IDLE: begin
                        TXD <= 1'b1;
                        if (!status[`ST_TX_EMPTY] && !tx_load_pulse) begin
                            tx_shift_reg  <= tx_holding_reg;
                            tx_extra      <= mp_mode ? status[`ST_MP_SEND] :
                                             parity_of(tx_holding_reg, char_bits, mode[`MODE_ODD]);
                            tx_load_pulse <= 1'b1;
                            tx_os         <= 5'd0;
                            tx_state      <= TX_START;
                        end
                    end
                    TX_START: begin
                        TXD <= 1'b0;
                        if (os_tick && tx_os == `OVERSAMPLE - 5'd1) begin
                            tx_bits  <= 4'd0;
                            tx_state <= TX_DATA;
                        end
                    end
                    TX_DATA: begin
                        TXD <= tx_shift_reg[0];
                        if (os_tick && tx_os == `OVERSAMPLE - 5'd1) begin
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                            tx_bits      <= tx_bits + 4'd1;
                            if (tx_bits == char_bits - 4'd1)
                                tx_state <= use_extra ? TX_EXTRA : TX_STOP;
                            tx_stop2 <= mode[`MODE_TWO_STOP];
                        end
                    end
                    TX_EXTRA: begin
                        TXD <= tx_extra;
                        if (os_tick && tx_os == `OVERSAMPLE - 5'd1)
                            tx_state <= TX_STOP;
                    end
                    TX_STOP: begin
                        TXD <= 1'b1;
                        if (os_tick && tx_os == `OVERSAMPLE - 5'd1) begin
                            if (tx_stop2) begin
                                tx_stop2 <= 1'b0;
                            end else begin
                                tx_state <= TX_IDLE;
                                if (status[`ST_TX_EMPTY])
                                    tx_end_pulse <= 1'b1;
                            end
                        end
                    end
                    default: tx_state <= TX_IDLE;
                endcase
            end
        end
    end

    // Internal serial clock: eight pulses per character, high when idle
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            sck_int   <= 1'b1;
            sck_prev  <= 1'b1;
            sck_run   <= 1'b0;
            sck_count <= 4'd0;
            SCK_OUT   <= 1'b1;
        end else begin
            sck_prev <= sck_line;
            SCK_OUT  <= sck_int;
            if (!sync_mode || ext_clk || !(tx_en || rx_en)) begin
                sck_int <= 1'b1;
                sck_run <= 1'b0;
            end else if (!sck_run) begin
                sck_int   <= 1'b1;
                sck_count <= 4'd0;
                if ((tx_en && !status[`ST_TX_EMPTY]) || (tx_en && tx_state == TX_DATA) ||
                    (!tx_en && rx_en && !status[`ST_RX_FULL]))
                    sck_run <= 1'b1;
            end else if (tick) begin
                sck_int <= ~sck_int;
                if (!sck_int) begin
                    sck_count <= sck_count + 4'd1;
                    // Receive-only bursts two characters, sixteen pulses
                    if ((tx_en && sck_count == 4'd7) || (!tx_en && sck_count == 4'd15))
                        sck_run <= 1'b0;
                end
            end
        end
    end

    // Receiver
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rx_state      <= 3'd0;
            rx_shift      <= 8'h00;
            rx_bits       <= 4'd0;
            rx_os         <= 5'd0;
            rx_extra      <= 1'b0;
            rx_stop_ok    <= 1'b0;
            rx_match      <= 1'b0;
            rx_second     <= 1'b0;
            rx_data       <= 8'h00;
            rx_done_pulse <= 1'b0;
        end else begin
            rx_done_pulse <= 1'b0;
            if (rx_done_pulse && !status[`ST_RX_FULL])
                rx_data <= rx_shift;
            if (!rx_en) begin
                rx_state <= 3'd0;
                rx_bits  <= 4'd0;
                rx_match <= 1'b0;
            end else if (sync_mode) begin
                if (sck_rise) begin
                    rx_shift <= {RXD, rx_shift[7:1]};
                    rx_bits  <= (rx_bits == 4'd7) ? 4'd0 : rx_bits + 4'd1;
                    if (rx_bits == 4'd7) begin
                        rx_extra      <= 1'b0;
                        rx_done_pulse <= 1'b1;
                        rx_second     <= ~rx_second;
                    end
                end
            end else begin
                if (os_tick)
                    rx_os <= rx_os + 5'd1;
                case (rx_state)
                    3'd0: begin
                        if (!RXD) begin
                            rx_os    <= 5'd0;
                            rx_bits  <= 4'd0;
                            rx_state <= 3'd1;
                        end
                    end
                    3'd1: begin
                        if (os_tick && rx_os == `MID_SAMPLE - 5'd1) begin
                            rx_os    <= 5'd0;
                            rx_state <= RXD ? 3'd0 : 3'd2;
                        end
                    end
                    3'd2: begin
                        if (os_tick && rx_os == `OVERSAMPLE - 5'd1) begin
                            rx_os <= 5'd0;
                            if (rx_bits < char_bits) begin
                                rx_shift <= (char_bits == 4'd7) ? {1'b0, RXD, rx_shift[7:2]} :
                                                                  {RXD, rx_shift[7:1]};
                                rx_bits  <= rx_bits + 4'd1;
                                if (rx_bits == char_bits - 4'd1 && !use_extra)
                                    rx_bits <= 4'd9;
                            end else if (rx_bits == char_bits) begin
                                rx_extra <= RXD;
                                rx_bits  <= 4'd9;
                            end else begin
                                rx_stop_ok <= RXD;
                                rx_state   <= 3'd0;
                                if (!mp_mode) begin
                                    rx_done_pulse <= 1'b1;
                                end else if (rx_extra) begin
                                    rx_match      <= (rx_shift == own_id);
                                    rx_done_pulse <= (rx_shift == own_id);
                                end else if (rx_match) begin
                                    rx_done_pulse <= 1'b1;
                                end
                                // Unmatched data frames dropped silently
                            end
                        end
                    end
                    default: rx_state <= 3'd0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/serial_port_asserts.sv
// Checker for the serial port unit: bus handshake, transmit flags and serial pins.
// Assumes it is bound to serial_port_unit and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module serial_port_asserts (
    // System
    input wire logic CLOCK,
    input wire logic RSTN,
    // Bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    // Requests and pins
    input wire logic DMA_WRITE,
    input wire logic TX_EMPTY_REQUEST,
    input wire logic TX_END_REQUEST,
    input wire logic TXD,
    input wire logic SCK_OUT,
    input wire logic SCK_OE_N
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    a_ack_answers: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    a_dma_clears: assert property (DMA_WRITE && TX_EMPTY_REQUEST |=> !TX_EMPTY_REQUEST)
        else $error("dma left empty flag");
    a_load_refill: assert property ($fell(TX_EMPTY_REQUEST) && TX_END_REQUEST
        |-> ##[1:4] (TX_EMPTY_REQUEST && !TX_END_REQUEST)) else $error("idle load missing");
    a_start_clears: assert property ($fell(TXD) && SCK_OE_N |-> !TX_END_REQUEST)
        else $error("start bit while ended");
    a_end_marks: assert property ($rose(TX_END_REQUEST) && SCK_OE_N |-> TXD) else $error("end not marking");
    a_sync_hold: assert property (!SCK_OE_N && $rose(SCK_OUT) |=> $stable(TXD))
        else $error("data moved while clock high");
    a_sck_idle: assert property ((!SCK_OE_N && TX_END_REQUEST) [*8] |-> SCK_OUT)
        else $error("idle clock low");
    c_dma: cover property (DMA_WRITE);
    c_end: cover property ($rose(TX_END_REQUEST));
    c_sck: cover property (!SCK_OE_N && $fell(SCK_OUT));
endmodule
bind serial_port_unit serial_port_asserts u_chk (.CLOCK, .RSTN, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .DMA_WRITE,
    .TX_EMPTY_REQUEST, .TX_END_REQUEST, .TXD, .SCK_OUT, .SCK_OE_N);
`default_nettype wire

//--- bench/remote_station.sv
// Far-side station: sends asynchronous frames carrying a multiprocessor bit.
// Assumes bit_clks system clocks per bit; the station drives the idle line to 1.
`timescale 1ns/1ns
`default_nettype none
module remote_station #(
    parameter int bit_clks = 32
) (
    input  wire logic clock,
    output var logic  rxd
);
    initial rxd = 1'b1;
    // Caller enters just after a rising edge
    task automatic send(input logic [7:0] data, input logic mp);
        logic [10:0] frame;
        frame = {1'b1, mp, data, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= frame[i];
            repeat (bit_clks) @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Bench for the serial port unit: register bus, frame formats, DMA, break, ID filter, sync output.
// Assumes remote_station drives the receive line at the async bit rate.
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_regs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
    logic        clock, rstn, cyc, stb, we, dma_write, ack, rxd, txd, sck_out, empty_req, end_req, full_req;
    logic [3:0]  adr;
    logic [7:0]  dma_data, rd;
    logic [31:0] wdat, dat_o;
    logic [21:0] bits;
    int          mismatches, num_checks;
    serial_port_unit u_dut (.CLOCK(clock), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .DMA_WRITE(dma_write), .DMA_DATA(dma_data), .TX_EMPTY_REQUEST(empty_req), .TX_END_REQUEST(end_req),
        .RX_FULL_REQUEST(full_req), .TXD(txd), .RXD(rxd), .SCK_IN(1'b1), .SCK_OUT(sck_out), .SCK_OE_N());
    remote_station u_far (.clock(clock), .rxd(rxd));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic guard(input logic ok);
        `CHK("timeout", 1'b1, ok)
        if (!ok) end_sim();
    endtask
    // Every task is entered just after a rising edge and returns just after one
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        // Ack and read data are looked at and taken mid-cycle; the strobe drops after the rising edge that follows
        do begin
            @(negedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat_o[7:0];
        @(posedge clock);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
        guard(n < 20);
    endtask
    task automatic grab(input int nb);
        int n;
        n = 0;
        bits = '1;
        while (txd !== 1'b0 && n < 600) begin
            @(posedge clock);
            n++;
        end
        guard(n < 600);
        repeat (16) @(posedge clock);
        for (int i = 0; i < nb; i++) begin
            bits[i] = txd;
            repeat (32) @(posedge clock);
        end
    endtask
    task automatic tx_formats;
        for (int f = 3; f >= 0; f--) begin
            bus(1'b1, `OFS_CONTROL, 8'h00);
            bus(1'b1, `OFS_MODE, {2'b00, 1'b1, f[1], 1'b0, 1'b1, f[0], 1'b0});
            bus(1'b1, `OFS_CONTROL, 8'h1f);
            bus(1'b1, `OFS_HOLDING, 8'ha5);
            bus(1'b1, `OFS_STATUS, 8'h7e);
            grab(12);
            `CHK("frame", f[0] ? {4'hf, 7'h25, 1'b0} : {3'b111, 8'ha5, 1'b0}, bits[11:0])
            `CHK("flags", 2'b11, {empty_req, end_req})
        end
    endtask
    task automatic tx_dma;
        bus(1'b1, `OFS_HOLDING, 8'h5a);
        bus(1'b1, `OFS_STATUS, 8'h7e);
        // Let the first load set the empty flag again before the DMA strobe
        repeat (2) @(posedge clock);
        dma_data <= 8'hc3;
        dma_write <= 1'b1;
        @(posedge clock);
        dma_write <= 1'b0;
        grab(22);
        `CHK("pair", {2'b11, 8'hc3, 1'b0, 2'b11, 8'h5a, 1'b0}, bits)
    endtask
    task automatic tx_break;
        bus(1'b1, `OFS_CONTROL, 8'h5f);
        bus(1'b1, `OFS_CONTROL, 8'h5e);
        @(posedge clock);
        `CHK("break", 1'b0, txd)
        bus(1'b1, `OFS_CONTROL, 8'h1e);
        bus(1'b1, `OFS_CONTROL, 8'h1f);
    endtask
    task automatic rx_mp;
        bus(1'b1, `OFS_OWN_ID, 8'h5a);
        u_far.send(8'h11, 1'b0);
        u_far.send(8'h22, 1'b1);
        u_far.send(8'h33, 1'b0);
        `CHK("skipped", 1'b0, full_req)
        u_far.send(8'h5a, 1'b1);
        bus(1'b0, `OFS_RXDATA, 8'h00);
        `CHK("id", 8'h5a, rd)
        bus(1'b1, `OFS_STATUS, 8'hfb);
        u_far.send(8'h44, 1'b0);
        bus(1'b0, `OFS_RXDATA, 8'h00);
        `CHK("data", 9'h144, {full_req, rd})
    endtask
    task automatic sync_tx;
        int rises;
        logic [7:0] got;
        logic last;
        bus(1'b1, `OFS_CONTROL, 8'h00);
        bus(1'b1, `OFS_MODE, 8'h01);
        bus(1'b1, `OFS_BAUD, 8'h03);
        bus(1'b1, `OFS_CONTROL, 8'h0d);
        bus(1'b1, `OFS_HOLDING, 8'hb4);
        bus(1'b1, `OFS_STATUS, 8'h3e);
        rises = 0;
        last = sck_out;
        repeat (300) begin
            @(posedge clock);
            if (sck_out && !last && rises < 8) got[rises] = txd;
            if (sck_out && !last) rises++;
            last = sck_out;
        end
        `CHK("sync data", 8'hb4, got)
        `CHK("sync pulses", 8, rises)
        `CHK("sync hold", 3'b111, {txd, end_req, sck_out})
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        {rstn, cyc, stb, we, dma_write, adr, dma_data, wdat} = '0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        bus(1'b0, `OFS_STATUS, 8'h00);
        `CHK("status", 8'h03, rd)
        bus(1'b0, 4'h7, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        bus(1'b0, `OFS_BAUD, 8'h00);
        `CHK("baud", 8'h07, rd)
        bus(1'b1, `OFS_BAUD, 8'h01);
        tx_formats();
        tx_dma();
        tx_break();
        rx_mp();
        sync_tx();
        end_sim();
    end
endmodule
`default_nettype wire
